// >>> oflvf_core.sv
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/10ps
module oflvf_core
  import oflvf_pkg::*;
#(
  parameter int RAMP_TICK = RAMP_TICK_CYCLES
)
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic second_function_select_in,
  input wire logic [ANA_BITS-1:0] analog_code_in,
  input wire logic [FW-1:0] supply_volt_in,
  output logic [FW-1:0] out_freq_out,
  output logic [FW-1:0] out_volt_out,
  output logic [FW-1:0] s_inflection_out,
  output logic s_inflection_valid_out
);
  // ==========================================
  // helpers
  function automatic logic [FW-1:0] cfg_init(input logic [4:0] idx);
    case (idx)
      IDX_MAX: cfg_init = F_120HZ;
      IDX_HSMAX: cfg_init = F_120HZ;
      IDX_JOG: cfg_init = F_JOG_INIT;
      IDX_START: cfg_init = F_START_INIT;
      IDX_BASEF: cfg_init = F_50HZ;
      IDX_BASEV: cfg_init = CODE_95PCT;
      IDX_SBASEF: cfg_init = CODE_OFF;
      IDX_MRV: cfg_init = MRV_INIT;
      IDX_MRF: cfg_init = F_50HZ;
      IDX_AGAIN: cfg_init = F_50HZ;
      IDX_STEP: cfg_init = STEP_INIT;
      default: cfg_init = (idx >= IDX_J1A && idx <= IDX_J3B) ? CODE_OFF : '0;
    endcase
  endfunction : cfg_init

  function automatic logic [FW-1:0] fmin(input logic [FW-1:0] a, input logic [FW-1:0] b);
    fmin = (a < b) ? a : b;
  endfunction : fmin

  function automatic logic [FW-1:0] fmax(input logic [FW-1:0] a, input logic [FW-1:0] b);
    fmax = (a > b) ? a : b;
  endfunction : fmax

  function automatic logic [FW-1:0] wr_fix(input logic [4:0] idx, input logic [FW-1:0] d);
    logic keep;
    keep = (d == CODE_OFF);
    if (idx == IDX_MAX)
      wr_fix = fmin(d, F_120HZ);
    else if (idx == IDX_HSMAX)
      wr_fix = fmax(F_120HZ, fmin(d, F_400HZ));
    else if (idx >= IDX_J1A && idx <= IDX_J3B)
      wr_fix = keep ? d : fmin(d, F_400HZ);
    else if (idx == IDX_BASEF)
      wr_fix = fmin(d, F_400HZ);
    else if (idx == IDX_SBASEF)
      wr_fix = keep ? d : fmin(d, F_400HZ);
    else if (idx == IDX_BASEV)
      wr_fix = (keep || d == CODE_95PCT) ? d : fmin(d, V_1000);
    else
      wr_fix = d;
  endfunction : wr_fix

  function automatic logic band_hit(input logic [FW-1:0] f, input logic [FW-1:0] a,
                                    input logic [FW-1:0] b);
    band_hit = (a != CODE_OFF) && (b != CODE_OFF) && (f >= fmin(a, b)) && (f <= fmax(a, b));
  endfunction : band_hit

  // ==========================================
  // apb slave
  logic [FW-1:0] cfg_q [NUM_CFG];
  logic [31:0] prdata_q;
  logic [FW-1:0] out_freq_q;
  logic [FW-1:0] out_volt_q;
  wire logic [4:0] a_idx = paddr_in[6:2];
  wire logic addr_ok = (paddr_in[1:0] == 2'h0) && !paddr_in[AW-1] && (a_idx <= IDX_STVOLT);
  wire logic is_ro = (a_idx == IDX_STFREQ) || (a_idx == IDX_STVOLT);
  wire logic access = psel_in && penable_in;
  wire logic setup = psel_in && !penable_in;
  wire logic bad = !addr_ok || (pwrite_in && is_ro);
  wire logic is_jump = (a_idx >= IDX_J1A) && (a_idx <= IDX_J3B);
  wire logic locked_grp = is_jump || (a_idx == IDX_BASEV) || (a_idx == IDX_HSMAX);
  wire logic wr_lock = (cfg_q[IDX_UGRS] != '0) && locked_grp;
  wire logic wr_en = access && pwrite_in && !bad && !wr_lock;
  wire logic [FW-1:0] w_val = wr_fix(a_idx, pwdata_in[FW-1:0]);
  wire logic w_pair = (a_idx == IDX_MAX) || (a_idx == IDX_HSMAX);
  wire logic [FW-1:0] rd_cfg = addr_ok ? cfg_q[a_idx] : '0;
  wire logic [FW-1:0] rd_stat = (a_idx == IDX_STFREQ) ? out_freq_q : out_volt_q;
  wire logic [FW-1:0] rd_val = is_ro ? rd_stat : rd_cfg;

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < NUM_CFG; i++)
        cfg_q[i] <= cfg_init(5'(i));
    end
    else if (wr_en)
    begin
      cfg_q[a_idx] <= w_val;
      if (w_pair)
      begin
        cfg_q[IDX_MAX] <= w_val;
        cfg_q[IDX_HSMAX] <= w_val;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      prdata_q <= '0;
    else if (setup)
      prdata_q <= {16'h0000, rd_val};
  end

  assign prdata_out = prdata_q;
  assign pready_out = 1'b1;
  assign pslverr_out = access && bad;

  // ==========================================
  // pin synchroniser
  logic sfs_meta_q;
  logic sfs_q;

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sfs_meta_q <= 1'b0;
      sfs_q <= 1'b0;
    end
    else
    begin
      sfs_meta_q <= second_function_select_in;
      sfs_q <= sfs_meta_q;
    end
  end

  // ==========================================
  // frequency command conditioning
  wire logic [FW-1:0] ctrl = cfg_q[IDX_CTRL];
  wire logic run = ctrl[CTRL_RUN];
  wire logic jog = ctrl[CTRL_JOG];
  wire logic [1:0] vec_mode = ctrl[CTRL_VEC +: 2];
  wire logic [FW-1:0] upper = cfg_q[IDX_MAX];
  wire logic [FW-1:0] lower = cfg_q[IDX_MIN];
  wire logic [FW-1:0] jog_f = cfg_q[IDX_JOG];
  wire logic [ANA_BITS+FW-1:0] ana_prod = analog_code_in * cfg_q[IDX_AGAIN];
  wire logic [FW-1:0] ana_f = ana_prod[ANA_BITS+FW-1:ANA_BITS];
  wire logic [FW-1:0] cmd_f = ctrl[CTRL_ANA] ? ana_f : cfg_q[IDX_CMD];
  wire logic [FW-1:0] clamped = fmin(cmd_f, upper);
  wire logic hit1 = band_hit(clamped, cfg_q[IDX_J1A], cfg_q[IDX_J1A+5'h01]);
  wire logic hit2 = band_hit(clamped, cfg_q[IDX_J1A+5'h02], cfg_q[IDX_J1A+5'h03]);
  wire logic hit3 = band_hit(clamped, cfg_q[IDX_J1A+5'h04], cfg_q[IDX_J3B]);
  wire logic [FW-1:0] jump_lo = hit2 ? cfg_q[IDX_J1A+5'h02] : (hit3 ? cfg_q[IDX_J1A+5'h04] : clamped);
  wire logic [FW-1:0] jumped = hit1 ? cfg_q[IDX_J1A] : jump_lo;

  wire logic [FW-1:0] run_f = fmax(jumped, lower);
  wire logic [FW-1:0] jog_t = (jog_f <= lower) ? jog_f : fmin(jog_f, upper);
  wire logic [FW-1:0] target_d = jog ? jog_t : (run ? run_f : '0);
  logic [FW-1:0] target_q;

  // ==========================================
  // acceleration ramp
  logic [31:0] tick_cnt_q;
  wire logic tick = (tick_cnt_q == 32'(RAMP_TICK - 1));
  wire logic [FW-1:0] step = cfg_q[IDX_STEP];
  wire logic [FW-1:0] goal = (target_q < cfg_q[IDX_START]) ? '0 : target_q;
  wire logic [FW:0] up_sum = {1'b0, out_freq_q} + {1'b0, step};
  wire logic [FW-1:0] up_f = (up_sum > {1'b0, goal}) ? goal : up_sum[FW-1:0];
  wire logic [FW-1:0] dn_f = (out_freq_q - goal > step) ? out_freq_q - step : goal;
  logic [FW-1:0] out_freq_d;

  always_comb
  begin
    out_freq_d = out_freq_q;
    if (tick && out_freq_q < goal)
      out_freq_d = up_f;
    else if (tick && out_freq_q > goal)
      out_freq_d = dn_f;
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      target_q <= '0;
      tick_cnt_q <= '0;
      out_freq_q <= '0;
    end
    else
    begin
      target_q <= target_d;
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 32'h00000001;
      out_freq_q <= out_freq_d;
    end
  end

  // ==========================================
  // base selection and voltage limit
  wire logic vector = (vec_mode != 2'h0);
  wire logic sbf_on = sfs_q && (cfg_q[IDX_SBASEF] != CODE_OFF);
  wire logic [FW-1:0] vf_base = sbf_on ? cfg_q[IDX_SBASEF] : cfg_q[IDX_BASEF];
  wire logic [FW-1:0] act_base = vector ? cfg_q[IDX_MRF] : vf_base;
  wire logic [FW-1:0] raw_v = vector ? cfg_q[IDX_MRV] : cfg_q[IDX_BASEV];
  wire logic [2*FW-1:0] v95_prod = supply_volt_in * PCT_95;
  wire logic [2*FW-1:0] v95_full = v95_prod / {16'h0000, PCT_100};
  wire logic [FW-1:0] v_code = (raw_v == CODE_95PCT) ? v95_full[FW-1:0] : supply_volt_in;
  wire logic use_code = !vector && ((raw_v == CODE_95PCT) || (raw_v == CODE_OFF));
  wire logic [FW-1:0] eff_v = use_code ? v_code : fmin(raw_v, supply_volt_in);

  wire logic [1:0] accel_pat = cfg_q[IDX_MODE][MODE_ACCEL +: 2];
  wire logic [1:0] load_pat = cfg_q[IDX_MODE][MODE_LOAD +: 2];
  assign s_inflection_valid_out = (accel_pat == ACCEL_S_A);
  assign s_inflection_out = s_inflection_valid_out ? vf_base : '0;

  // ==========================================
  // v/f curve
  oflvf_div_req_type div_req;
  logic div_busy;
  logic div_done;
  logic [DIV_NUM_W-1:0] div_quot;
  logic [12:0] ratio_q;
  logic [FW-1:0] f_cap_q;
  logic [FW-1:0] base_q;
  wire logic [FW-1:0] f_cap = fmin(out_freq_q, act_base);
  assign div_req.num = {f_cap, {RATIO_SH{1'b0}}};
  assign div_req.den = act_base;

  oflvf_div i_oflvf_div (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .start_in(!div_busy),
    .req_in(div_req),
    .busy_out(div_busy),
    .done_out(div_done),
    .quot_out(div_quot)
  );

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      f_cap_q <= '0;
      base_q <= '0;
    end
    else if (!div_busy)
    begin
      f_cap_q <= f_cap;
      base_q <= act_base;
    end
  end

  // ratio rounded up, exact volt points stay exact
  wire logic [28:0] back_prod = div_quot[12:0] * base_q;
  wire logic inexact = (back_prod != {1'b0, f_cap_q, {RATIO_SH{1'b0}}});
  wire logic [12:0] ratio_d = (base_q == '0) ? RATIO_ONE : div_quot[12:0] + 13'(inexact);
  wire logic [25:0] sq_prod = ratio_q * ratio_q;
  wire logic [12:0] sq_ratio = sq_prod[24:12];
  wire logic square = !vector && (load_pat == LOAD_SQUARE);
  wire logic [12:0] use_ratio = square ? sq_ratio : ratio_q;
  wire logic [28:0] v_prod = eff_v * use_ratio;
  wire logic [FW-1:0] v_out = fmin(v_prod[27:12], supply_volt_in);

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ratio_q <= '0;
      out_volt_q <= '0;
    end
    else
    begin
      if (div_done)
        ratio_q <= ratio_d;
      out_volt_q <= v_out;
    end
  end

  assign out_freq_out = out_freq_q;
  assign out_volt_out = out_volt_q;

  // ==========================================
  // assertions
  property p_max_clamp;
    @(posedge clock_in) disable iff (!rstn_in)
    run && !jog && cmd_f > upper && !hit1 && !hit2 && !hit3 && upper >= lower |=> target_q == $past(upper);
  endproperty
  a_max_clamp: assert property (p_max_clamp) else $error("command not clamped at maximum");

  property p_hs_limit;
    @(posedge clock_in) disable iff (!rstn_in)
    wr_en && a_idx == IDX_MAX && pwdata_in[FW-1:0] > F_120HZ |=> cfg_q[IDX_MAX] == F_120HZ;
  endproperty
  a_hs_limit: assert property (p_hs_limit) else $error("maximum setting passed 120Hz");

  property p_pair_copy;
    @(posedge clock_in) disable iff (!rstn_in)
    wr_en && w_pair |=> cfg_q[IDX_MAX] == cfg_q[IDX_HSMAX] && cfg_q[IDX_MAX] == $past(w_val);
  endproperty
  a_pair_copy: assert property (p_pair_copy) else $error("maximum settings differ");

  property p_min_hold;
    @(posedge clock_in) disable iff (!rstn_in)
    run && !jog && jumped < lower |=> target_q == $past(lower);
  endproperty
  a_min_hold: assert property (p_min_hold) else $error("minimum not held");

  property p_jog_prec;
    @(posedge clock_in) disable iff (!rstn_in)
    jog && jog_f <= lower |=> target_q == $past(jog_f);
  endproperty
  a_jog_prec: assert property (p_jog_prec) else $error("jog not given precedence");

  property p_jump_a;
    @(posedge clock_in) disable iff (!rstn_in)
    run && !jog && hit1 && cfg_q[IDX_J1A] >= lower |=> target_q == $past(cfg_q[IDX_J1A]);
  endproperty
  a_jump_a: assert property (p_jump_a) else $error("jump band not held at A");

  property p_ramp_step;
    @(posedge clock_in) disable iff (!rstn_in)
    out_freq_q > $past(out_freq_q) |-> out_freq_q - $past(out_freq_q) <= $past(step);
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp skipped frequencies");

  property p_supply_cap;
    @(posedge clock_in) disable iff (!rstn_in)
    ##1 1'b1 |-> out_volt_q <= $past(supply_volt_in);
  endproperty
  a_supply_cap: assert property (p_supply_cap) else $error("voltage above supply");

  property p_lock;
    @(posedge clock_in) disable iff (!rstn_in)
    access && pwrite_in && a_idx == IDX_BASEV && cfg_q[IDX_UGRS] != '0 |=> $stable(cfg_q[IDX_BASEV]);
  endproperty
  a_lock: assert property (p_lock) else $error("locked setting changed");

  property p_second_base;
    @(posedge clock_in) disable iff (!rstn_in)
    sfs_q && cfg_q[IDX_SBASEF] != CODE_OFF && !vector |-> act_base == cfg_q[IDX_SBASEF];
  endproperty
  a_second_base: assert property (p_second_base) else $error("second base not used");

  c_jog: cover property (@(posedge clock_in) disable iff (!rstn_in) jog && jog_f <= lower);
  c_jump: cover property (@(posedge clock_in) disable iff (!rstn_in) run && hit1);
  c_pair: cover property (@(posedge clock_in) disable iff (!rstn_in) wr_en && a_idx == IDX_HSMAX);
  c_ramp: cover property (@(posedge clock_in) disable iff (!rstn_in) tick && out_freq_q != '0);
endmodule : oflvf_core

// >>> oflvf_div.sv
`timescale 1ns/10ps
module oflvf_div
  import oflvf_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire oflvf_div_req_type req_in,
  output logic busy_out,
  output logic done_out,
  output logic [DIV_NUM_W-1:0] quot_out
);
  // ==========================================
  // restoring divider, one bit per cycle
  oflvf_div_state_type state_q;
  logic [4:0] cnt_q;
  logic [FW:0] rem_q;
  logic [DIV_NUM_W-1:0] quo_q;
  logic [FW-1:0] den_q;
  logic done_q;
  wire logic [FW:0] shifted = {rem_q[FW-1:0], quo_q[DIV_NUM_W-1]};
  wire logic [FW:0] trial = shifted - {1'b0, den_q};
  wire logic fits = !trial[FW];

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_q <= DIV_IDLE;
      cnt_q <= '0;
      rem_q <= '0;
      quo_q <= '0;
      den_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (state_q)
        DIV_IDLE:
        begin
          if (start_in)
          begin
            quo_q <= req_in.num;
            den_q <= req_in.den;
            rem_q <= '0;
            cnt_q <= '0;
            state_q <= DIV_RUN;
          end
        end
        DIV_RUN:
        begin
          rem_q <= fits ? trial : shifted;
          quo_q <= {quo_q[DIV_NUM_W-2:0], fits};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == DIV_LAST)
          begin
            done_q <= 1'b1;
            state_q <= DIV_IDLE;
          end
        end
        default: state_q <= DIV_IDLE;
      endcase
    end
  end

  assign busy_out = (state_q != DIV_IDLE);
  assign done_out = done_q;
  assign quot_out = quo_q;
endmodule : oflvf_div

// >>> oflvf_drive_model.sv
`timescale 1ns/10ps
// ==========================================
// external command inputs and supply of the drive
module oflvf_drive_model
  import oflvf_pkg::*;
#(
  parameter logic [FW-1:0] SUPPLY_V = 16'h0190
)
(
  input wire logic clock_in,
  input wire logic sfs_req_in,
  input wire logic [ANA_BITS-1:0] ana_req_in,
  output logic second_function_select_out,
  output logic [ANA_BITS-1:0] analog_code_out,
  output logic [FW-1:0] supply_volt_out
);
  assign supply_volt_out = SUPPLY_V;
  initial
  begin
    second_function_select_out = 1'b0;
    analog_code_out = '0;
  end
  // terminal assigned to second function and analog command input
  always @(posedge clock_in)
  begin
    second_function_select_out <= sfs_req_in;
    analog_code_out <= ana_req_in;
  end
endmodule : oflvf_drive_model

// >>> oflvf_pkg.sv
package oflvf_pkg;
  // ==========================================
  // widths and timing
  localparam int FW = 16;
  localparam int AW = 8;
  localparam int ANA_BITS = 10;
  localparam int RATIO_SH = 12;
  localparam int DIV_NUM_W = 28;
  localparam int NUM_CFG = 22;
  localparam int CLK_PERIOD_NS = 5;
  localparam int RAMP_TICK_NS = 1000000;
  localparam int RAMP_TICK_CYCLES = RAMP_TICK_NS / CLK_PERIOD_NS;
  // ==========================================
  // register indices, byte address is index times four
  localparam logic [4:0] IDX_CMD = 5'h00;
  localparam logic [4:0] IDX_CTRL = 5'h01;
  localparam logic [4:0] IDX_MAX = 5'h02;
  localparam logic [4:0] IDX_HSMAX = 5'h03;
  localparam logic [4:0] IDX_MIN = 5'h04;
  localparam logic [4:0] IDX_JOG = 5'h05;
  localparam logic [4:0] IDX_START = 5'h06;
  localparam logic [4:0] IDX_J1A = 5'h07;
  localparam logic [4:0] IDX_J3B = 5'h0C;
  localparam logic [4:0] IDX_BASEF = 5'h0D;
  localparam logic [4:0] IDX_BASEV = 5'h0E;
  localparam logic [4:0] IDX_SBASEF = 5'h0F;
  localparam logic [4:0] IDX_MRV = 5'h10;
  localparam logic [4:0] IDX_MRF = 5'h11;
  localparam logic [4:0] IDX_MODE = 5'h12;
  localparam logic [4:0] IDX_UGRS = 5'h13;
  localparam logic [4:0] IDX_AGAIN = 5'h14;
  localparam logic [4:0] IDX_STEP = 5'h15;
  localparam logic [4:0] IDX_STFREQ = 5'h16;
  localparam logic [4:0] IDX_STVOLT = 5'h17;
  // ==========================================
  // field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_JOG = 1;
  localparam int CTRL_ANA = 2;
  localparam int CTRL_VEC = 3;
  localparam int MODE_LOAD = 0;
  localparam int MODE_ACCEL = 2;
  localparam logic [1:0] LOAD_SQUARE = 2'h1;
  localparam logic [1:0] ACCEL_S_A = 2'h1;
  // ==========================================
  // values, frequency lsb 0.1Hz, voltage lsb 1V
  localparam logic [FW-1:0] F_50HZ = 16'h01F4;
  localparam logic [FW-1:0] F_120HZ = 16'h04B0;
  localparam logic [FW-1:0] F_400HZ = 16'h0FA0;
  localparam logic [FW-1:0] F_JOG_INIT = 16'h0032;
  localparam logic [FW-1:0] F_START_INIT = 16'h0005;
  localparam logic [FW-1:0] STEP_INIT = 16'h0001;
  localparam logic [FW-1:0] CODE_OFF = 16'h270F;
  localparam logic [FW-1:0] CODE_95PCT = 16'h22B8;
  localparam logic [FW-1:0] V_1000 = 16'h03E8;
  localparam logic [FW-1:0] MRV_INIT = 16'h0190;
  localparam logic [FW-1:0] PCT_95 = 16'h005F;
  localparam logic [FW-1:0] PCT_100 = 16'h0064;
  localparam logic [12:0] RATIO_ONE = 13'h1000;
  localparam logic [4:0] DIV_LAST = 5'h1B;
  // ==========================================
  // types
  typedef struct packed {
    logic [DIV_NUM_W-1:0] num;
    logic [FW-1:0] den;
  } oflvf_div_req_type;
  typedef enum logic [1:0] {
    DIV_IDLE = 2'b01,
    DIV_RUN = 2'b10
  } oflvf_div_state_type;
endpackage : oflvf_pkg

// >>> output_frequency_limit_vf_tb.sv
`timescale 1ns/10ps
module output_frequency_limit_vf_tb
  import oflvf_pkg::*;
;
  logic clock_in, rstn_in, psel, penable, pwrite, pready, pslverr, sfs, sfs_req, sinfv;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [ANA_BITS-1:0] ana, ana_req;
  logic [FW-1:0] supply, ofreq, ovolt, sinf;
  logic [32:0] exp_q[$];
  logic [15:0] lfsr;
  int err_total, num_checks, cyc;
  logic [7:0] ia[7] = '{8'h14, 8'h18, 8'h1C, 8'h34, 8'h38, 8'h3C, 8'h54};
  logic [15:0] iv[7] = '{16'h0032, 16'h0005, 16'h270F, 16'h01F4, 16'h22B8, 16'h270F, 16'h0001};
  logic [15:0] ja[3] = '{16'h012C, 16'h02BC, 16'h270F};
  logic [15:0] jb[3] = '{16'h0190, 16'h028A, 16'h0320};
  logic [15:0] jc[3] = '{16'h015E, 16'h02A8, 16'h0352};
  logic [15:0] jx[3] = '{16'h012C, 16'h02BC, 16'h0352};
  int jv[3] = '{228, 380, 380};
  logic [15:0] bc[4] = '{16'h22B8, 16'h270F, 16'h012C, 16'h03E8};
  int bv[4] = '{380, 400, 300, 400};
  oflvf_core #(.RAMP_TICK(8)) i_oflvf_core (.clock_in(clock_in), .rstn_in(rstn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .second_function_select_in(sfs), .analog_code_in(ana),
    .supply_volt_in(supply), .out_freq_out(ofreq), .out_volt_out(ovolt), .s_inflection_out(sinf),
    .s_inflection_valid_out(sinfv));
  oflvf_drive_model i_oflvf_drive_model (.clock_in(clock_in), .sfs_req_in(sfs_req), .ana_req_in(ana_req),
    .second_function_select_out(sfs), .analog_code_out(ana), .supply_volt_out(supply));
  // ==========================================
  // clock, timeout, result monitor
  initial
  begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_total++;
      give_verdict();
    end
  end
  always @(posedge clock_in)
    if (psel && penable && pready)
    begin
      chk({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
    end
  // ==========================================
  // tasks
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic chk(input logic [32:0] seen, input logic [32:0] expv);
    num_checks++;
    if (seen !== expv)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [32:0] e);
    @(posedge clock_in);
    lfsr = lfsr_next(lfsr);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {lfsr, d};
    exp_q.push_back(e);
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1) @(posedge clock_in);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic err = 1'b0);
    xfer(1'b1, a, d, {err, 32'h0});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic err = 1'b0);
    xfer(1'b0, a, 16'h0000, {err, 16'h0000, d});
  endtask : rd
  task automatic run(input logic [15:0] cmd, input logic [15:0] f, input int v);
    int n;
    n = 0;
    wr(8'h00, cmd);
    while (ofreq !== f && n < 4000)
    begin
      @(posedge clock_in);
      n++;
    end
    repeat (64) @(posedge clock_in);
    rd(8'h58, f);
    if (v >= 0) rd(8'h5C, v[15:0]);
  endtask : run
  // ==========================================
  // main sequence
  initial
  begin
    {rstn_in, psel, penable, pwrite, sfs_req} = '0;
    paddr = '0;
    pwdata = '0;
    ana_req = '0;
    lfsr = 16'h847B;
    repeat (16) @(posedge clock_in);
    rstn_in <= 1'b1;
    foreach (ia[i]) rd(ia[i], iv[i]);
    rd(8'h60, 16'h0000, 1'b1);
    wr(8'h58, 16'h0001, 1'b1);
    wr(8'h54, 16'h0064);
    wr(8'h04, 16'h0001);
    wr(8'h08, 16'h0258);
    run(16'h03E8, 16'h0258, 380);
    wr(8'h0C, 16'h05DC);
    rd(8'h08, 16'h05DC);
    run(16'h07D0, 16'h05DC, 380);
    run(16'h0640 + {6'h00, lfsr[9:0]}, 16'h05DC, 380);
    wr(8'h08, 16'h07D0);
    rd(8'h0C, 16'h04B0);
    wr(8'h08, 16'h044C);
    rd(8'h0C, 16'h044C);
    wr(8'h10, 16'h00C8);
    run(16'h0064, 16'h00C8, 152);
    run(16'h0000, 16'h00C8, 152);
    wr(8'h14, 16'h0096);
    wr(8'h04, 16'h0003);
    run(16'h0064, 16'h0096, 114);
    wr(8'h04, 16'h0001);
    // lower value as A holds at bottom, higher as A at top
    foreach (ja[k])
    begin
      wr(8'h1C + 8'(8 * k), ja[k]);
      wr(8'h20 + 8'(8 * k), jb[k]);
      run(jc[k], jx[k], jv[k]);
    end
    wr(8'h4C, 16'h0001);
    wr(8'h1C, 16'h01F4);
    rd(8'h1C, 16'h012C);
    wr(8'h38, 16'h012C);
    rd(8'h38, 16'h22B8);
    wr(8'h4C, 16'h0000);
    foreach (bc[k])
    begin
      wr(8'h38, bc[k]);
      run(16'h0258, 16'h0258, bv[k]);
    end
    wr(8'h38, 16'h017C);
    run(16'h00FA, 16'h00FA, 190);
    wr(8'h48, 16'h0001);
    run(16'h00FA, 16'h00FA, 95);
    wr(8'h48, 16'h0004);
    wr(8'h3C, 16'h00FA);
    sfs_req <= 1'b1;
    run(16'h00FA, 16'h00FA, 380);
    chk({16'h0000, sinfv, sinf}, {16'h0000, 1'b1, 16'h00FA});
    wr(8'h3C, 16'h270F);
    run(16'h00FA, 16'h00FA, 190);
    sfs_req <= 1'b0;
    wr(8'h38, 16'h012C);
    wr(8'h04, 16'h0009);
    run(16'h0258, 16'h0258, 400);
    chk({16'h0000, sinfv, sinf}, {16'h0000, 1'b1, 16'h01F4});
    wr(8'h04, 16'h0005);
    ana_req <= 10'h3FF;
    run(16'h0000, 16'h01F3, -1);
    wr(8'h50, 16'h03E8);
    run(16'h0000, 16'h03E7, -1);
    give_verdict();
  end
endmodule : output_frequency_limit_vf_tb
